// *** rtl/sif_supervisor.sv ***
/*
  Shutter and interlock fault supervisor with an AXI4-Lite register slave.
  Assumes one 125 MHz clock, synchronous active-low reset, and raw
  asynchronous interlock and position-sense pins.
*/
`timescale 1ns/10ps
`default_nettype none
`include "sif_params.svh"

// Functional notes
// - shutter command high opens, low closes
// - open status only when present and sensed open
// - any system fault disables shutter, status low
// - travel timeout raises shutter latching fault
// - commanded closed without closed sense faults
// - position judged open, closed or neither
// - shutter fault shuts whole system down
// - over-temperature output on any controller report
// - over-temperature latches and shuts system down
// - laser runs only with system loop closed
// - shutter loop gates shutter only, not system
// - interlock-satisfied flag enables laser operation
// - closed status when present and closed only
// - modulation only while system interlock satisfied
module sif_supervisor import sif_pkg::*; #(
  parameter int unsigned TRAVEL_CYCLES = `SIF_TRAVEL_CYC,
  parameter int unsigned NUM_TEMP = 4
) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // host machine pins
  input wire logic shutter_cmd,
  input wire logic sys_loop_closed,
  input wire logic shut_loop_closed,
  // shutter mechanism
  input wire logic sense_open,
  input wire logic sense_closed,
  output logic shutter_drive_open,
  output logic shutter_enable,
  // peripheral temperature reports
  input wire logic [NUM_TEMP-1:0] temp_out_of_range,
  // status pins
  output logic shutter_open_status,
  output logic shutter_closed_status,
  output logic shutter_fault,
  output logic overtemp_fault,
  output logic interlock_ok,
  output logic modulation_enable,
  output logic system_run,
  // axi4-lite write address
  input wire logic [3:0] s_awaddr,
  input wire logic s_awvalid,
  output logic s_awready,
  // axi4-lite write data
  input wire logic [31:0] s_wdata,
  input wire logic [3:0] s_wstrb,
  input wire logic s_wvalid,
  output logic s_wready,
  // axi4-lite write response
  output logic [1:0] s_bresp,
  output logic s_bvalid,
  input wire logic s_bready,
  // axi4-lite read address
  input wire logic [3:0] s_araddr,
  input wire logic s_arvalid,
  output logic s_arready,
  // axi4-lite read data
  output logic [31:0] s_rdata,
  output logic [1:0] s_rresp,
  output logic s_rvalid,
  input wire logic s_rready
);

  localparam int CW = $clog2(TRAVEL_CYCLES + 1);
  localparam int NS = 4 + NUM_TEMP;

  initial begin
    if (TRAVEL_CYCLES < 2 || NUM_TEMP < 1) begin
      $error("sif_supervisor: bad parameters");
    end
  end

  typedef struct packed {
    logic [NS-1:0] s1, s2, s3;
    logic [NS-1:0] flt;
    sif_shut_e shut;
    logic [CW-1:0] tmr;
    logic sfault, ofault;
    logic cmd_sw, present_sw;
    logic aw_got, w_got;
    logic [3:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [1:0] rresp;
    logic [31:0] rdata;
    logic open_st, closed_st, drive, en, ilk, mod, run;
  } sif_state_s;

  sif_state_s q_reg, q_next;

  logic [NS-1:0] raw;
  assign raw = {temp_out_of_range, sense_closed, sense_open, shut_loop_closed, sys_loop_closed};

  logic sys_ok, shut_ok, s_open, s_closed, any_temp, cmd_open, sys_fault, present;
  logic moving, neither;
  // the host command pin passes its own three-stage filter
  logic [2:0] cmd_sy_reg;
  logic pin_cmd_f;

  always_comb begin
    q_next = q_reg;
    // input filter: a bit changes only when stages two and three agree
    q_next.s1 = raw;
    q_next.s2 = q_reg.s1;
    q_next.s3 = q_reg.s2;
    for (int i = 0; i < NS; i++) begin
      if (q_reg.s2[i] == q_reg.s3[i]) begin
        q_next.flt[i] = q_reg.s3[i];
      end
    end
    sys_ok = q_reg.flt[0];
    shut_ok = q_reg.flt[1];
    s_open = q_reg.flt[2];
    s_closed = q_reg.flt[3];
    any_temp = |q_reg.flt[NS-1:4];
    // present when loop closed or software strapped it
    present = shut_ok | q_reg.present_sw;
    cmd_open = q_reg.cmd_sw | pin_cmd_f;
    sys_fault = q_reg.sfault | q_reg.ofault;
    moving = (q_reg.shut == SH_OPENING) || (q_reg.shut == SH_CLOSING);
    neither = !s_open && !s_closed;

    // shutter only runs with its loop closed
    if (!shut_ok || sys_fault) begin
      q_next.shut = SH_CLOSED;
      q_next.tmr = '0;
    end else begin
      unique case (q_reg.shut)
        SH_CLOSED: begin
          if (cmd_open) begin
            q_next.shut = SH_OPENING;
            q_next.tmr = '0;
          end
        end
        SH_OPEN: begin
          if (!cmd_open) begin
            q_next.shut = SH_CLOSING;
            q_next.tmr = '0;
          end
        end
        SH_OPENING: begin
          if (!cmd_open) begin
            q_next.shut = SH_CLOSING;
            q_next.tmr = '0;
          end else if (s_open && !s_closed) begin
            q_next.shut = SH_OPEN;
          end else begin
            q_next.tmr = q_reg.tmr + 1'b1;
          end
        end
        SH_CLOSING: begin
          if (cmd_open) begin
            q_next.shut = SH_OPENING;
            q_next.tmr = '0;
          end else if (s_closed && !s_open) begin
            q_next.shut = SH_CLOSED;
          end else begin
            q_next.tmr = q_reg.tmr + 1'b1;
          end
        end
      endcase
    end

    // latched faults clear only via reset or software
    // clear comes first so a fault event in the same cycle wins
    if (q_reg.aw_got && q_reg.w_got && q_reg.awaddr == `SIF_ADDR_CTRL && q_reg.wstrb[0]
        && q_reg.wdata[`SIF_CTRL_CLR_BIT] && !any_temp) begin
      q_next.ofault = 1'b0;
      q_next.sfault = 1'b0;
    end
    if (shut_ok && moving && q_reg.tmr >= CW'(TRAVEL_CYCLES)) begin
      q_next.sfault = 1'b1;
    end
    if (shut_ok && !moving && !cmd_open && q_reg.shut == SH_CLOSED && (neither || s_open)) begin
      q_next.sfault = 1'b1;
    end
    if (any_temp) begin
      q_next.ofault = 1'b1;
    end

    q_next.en = shut_ok && !sys_fault;
    q_next.drive = shut_ok && !sys_fault && cmd_open;
    q_next.open_st = present && s_open && !s_closed && !sys_fault;
    q_next.closed_st = present && s_closed && !s_open && !sys_fault;
    q_next.ilk = sys_ok;
    // system loop dominates, faults shut down
    q_next.run = sys_ok && !q_next.sfault && !q_next.ofault;
    q_next.mod = sys_ok && !q_next.sfault && !q_next.ofault;

    // axi4-lite write side
    if (s_awvalid && !q_reg.aw_got) begin
      q_next.aw_got = 1'b1;
      q_next.awaddr = s_awaddr;
    end
    if (s_wvalid && !q_reg.w_got) begin
      q_next.w_got = 1'b1;
      q_next.wdata = s_wdata;
      q_next.wstrb = s_wstrb;
    end
    if (q_reg.aw_got && q_reg.w_got && !q_reg.bvalid) begin
      q_next.aw_got = 1'b0;
      q_next.w_got = 1'b0;
      q_next.bvalid = 1'b1;
      if (q_reg.awaddr == `SIF_ADDR_CTRL) begin
        q_next.bresp = `SIF_RESP_OKAY;
        if (q_reg.wstrb[0]) begin
          q_next.cmd_sw = q_reg.wdata[`SIF_CTRL_CMD_BIT];
          q_next.present_sw = q_reg.wdata[`SIF_CTRL_PRES_BIT];
        end
      end else begin
        q_next.bresp = `SIF_RESP_SLVERR;
      end
    end
    if (q_reg.bvalid && s_bready) begin
      q_next.bvalid = 1'b0;
    end

    // axi4-lite read side
    if (s_arvalid && !q_reg.rvalid) begin
      q_next.rvalid = 1'b1;
      q_next.rresp = `SIF_RESP_OKAY;
      unique case (s_araddr)
        `SIF_ADDR_CTRL: q_next.rdata = {29'h0, 1'b0, q_reg.present_sw, q_reg.cmd_sw};
        `SIF_ADDR_STAT: q_next.rdata = {22'h0, q_reg.shut, q_reg.run, q_reg.mod, q_reg.ilk,
                                        q_reg.ofault, q_reg.sfault, q_reg.closed_st,
                                        q_reg.open_st, shut_ok};
        default: begin
          q_next.rdata = 32'h0;
          q_next.rresp = `SIF_RESP_SLVERR;
        end
      endcase
    end
    if (q_reg.rvalid && s_rready) begin
      q_next.rvalid = 1'b0;
    end
  end

  // filtered command pin; the raw pin is never used directly
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmd_sy_reg <= 3'h0;
      pin_cmd_f <= 1'b0;
    end else begin
      cmd_sy_reg <= {cmd_sy_reg[1:0], shutter_cmd};
      if (cmd_sy_reg[1] == cmd_sy_reg[2]) begin
        pin_cmd_f <= cmd_sy_reg[2];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      q_reg <= '0;
    end else begin
      q_reg <= q_next;
    end
  end

  assign s_awready = !q_reg.aw_got;
  assign s_wready = !q_reg.w_got;
  assign s_bvalid = q_reg.bvalid;
  assign s_bresp = q_reg.bresp;
  assign s_arready = !q_reg.rvalid;
  assign s_rvalid = q_reg.rvalid;
  assign s_rdata = q_reg.rdata;
  assign s_rresp = q_reg.rresp;
  assign shutter_drive_open = q_reg.drive;
  assign shutter_enable = q_reg.en;
  assign shutter_open_status = q_reg.open_st;
  assign shutter_closed_status = q_reg.closed_st;
  assign shutter_fault = q_reg.sfault;
  assign overtemp_fault = q_reg.ofault;
  assign interlock_ok = q_reg.ilk;
  assign modulation_enable = q_reg.mod;
  assign system_run = q_reg.run;

endmodule
`default_nettype wire

// *** rtl/sif_params.svh ***
/*
  Timing and register-map constants for the shutter interlock supervisor.
  Assumes inclusion by bare name from rtl/; definitions only.
*/
`ifndef SIF_PARAMS_SVH
`define SIF_PARAMS_SVH

`define SIF_CLK_MHZ 125
`define SIF_TRAVEL_MS 100
`define SIF_TRAVEL_CYC (`SIF_TRAVEL_MS * `SIF_CLK_MHZ * 1000)
`define SIF_ADDR_CTRL 4'h0
`define SIF_ADDR_STAT 4'h4
`define SIF_CTRL_RESET 3'h0
`define SIF_CTRL_CMD_BIT 0
`define SIF_CTRL_PRES_BIT 1
`define SIF_CTRL_CLR_BIT 2
`define SIF_RESP_OKAY 2'h0
`define SIF_RESP_SLVERR 2'h2

`endif

// *** rtl/sif_pkg.sv ***
/*
  Types for the shutter interlock supervisor.
  Assumes the params header is compiled alongside.
*/
package sif_pkg;
  typedef enum logic [1:0] {SH_CLOSED, SH_OPENING, SH_OPEN, SH_CLOSING} sif_shut_e;
endpackage

// *** test/sif_supervisor_props.sv ***
/* port assertions for sif_supervisor;
   bound into every instance, sees its ports only */
`timescale 1ns/10ps
`default_nettype none
module sif_supervisor_props #(parameter int unsigned NUM_TEMP = 4) (
  // clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // pins
  input wire logic sys_loop_closed,
  input wire logic shut_loop_closed,
  input wire logic sense_open,
  input wire logic [NUM_TEMP-1:0] temp_out_of_range,
  input wire logic shutter_drive_open,
  input wire logic shutter_open_status,
  input wire logic shutter_closed_status,
  input wire logic shutter_fault,
  input wire logic overtemp_fault,
  input wire logic interlock_ok,
  input wire logic modulation_enable,
  input wire logic system_run
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic flt;
  // two fault cycles: status may lag the fault by one edge
  assign flt = shutter_fault | overtemp_fault;
  property p_open; flt && $past(flt) |-> !shutter_open_status; endproperty
  a_open: assert property (p_open) else $error("open status in fault");
  property p_closed; flt && $past(flt) |-> !shutter_closed_status; endproperty
  a_closed: assert property (p_closed) else $error("closed status in fault");
  property p_run; flt && $past(flt) |-> !system_run; endproperty
  a_run: assert property (p_run) else $error("run in fault");
  property p_mod; !sys_loop_closed [*8] |-> !modulation_enable; endproperty
  a_mod: assert property (p_mod) else $error("modulation with loop open");
  property p_ok; !sys_loop_closed [*8] |-> !interlock_ok; endproperty
  a_ok: assert property (p_ok) else $error("interlock ok with loop open");
  property p_sense; !sense_open [*8] |-> !shutter_open_status; endproperty
  a_sense: assert property (p_sense) else $error("open status unsensed");
  property p_shl; !shut_loop_closed [*8] |-> !shutter_drive_open; endproperty
  a_shl: assert property (p_shl) else $error("drive with shutter loop open");
  property p_temp; (|temp_out_of_range) [*8] |-> overtemp_fault; endproperty
  a_temp: assert property (p_temp) else $error("no overtemp fault");
  c_sf: cover property ($rose(shutter_fault));
  c_ot: cover property ($rose(overtemp_fault));
  c_open: cover property ($rose(shutter_open_status));
endmodule
bind sif_supervisor sif_supervisor_props #(.NUM_TEMP(NUM_TEMP)) u_props (.aclk, .aresetn,
  .sys_loop_closed, .shut_loop_closed, .sense_open, .temp_out_of_range, .shutter_drive_open,
  .shutter_open_status, .shutter_closed_status, .shutter_fault, .overtemp_fault,
  .interlock_ok, .modulation_enable, .system_run);
`default_nettype wire

// *** test/sif_shutter_model.sv ***
/* spring-return shutter blade with open and closed sensors;
   driven by the supervisor's drive and enable outputs */
`timescale 1ns/10ps
`default_nettype none
module sif_shutter_model #(parameter int MOVE = 8) (
  // clock
  input wire logic aclk,
  // drive and test controls
  input wire logic drive_open,
  input wire logic enable,
  input wire logic slow,
  input wire logic stuck,
  // sensors
  output logic sense_open,
  output logic sense_closed
);
  int pos = 0;
  logic [1:0] div = 2'h0;
  // slow: one step in four, beyond the travel limit
  always @(posedge aclk) begin
    div <= div + 2'h1;
    if (!stuck && (!slow || div == 2'h0)) begin
      if (drive_open && enable)
        pos <= (pos < MOVE) ? pos + 1 : pos;
      else
        pos <= (pos > 0) ? pos - 1 : pos;
    end
  end
  assign sense_open = (pos == MOVE);
  assign sense_closed = (pos == 0);
endmodule
`default_nettype wire

// *** test/sif_supervisor_tb.sv ***
/* self-checking bench for sif_supervisor with a shutter model;
   assumes the params header on the include path */
`timescale 1ns/10ps
`default_nettype none
`include "sif_params.svh"
module sif_supervisor_tb;
  logic aclk = 1'b0, aresetn = 1'b0, shutter_cmd = 1'b0, sys_loop_closed = 1'b0;
  logic shut_loop_closed = 1'b0, slow = 1'b0, stuck = 1'b0, s_awvalid = 1'b0;
  logic s_wvalid = 1'b0, s_bready = 1'b0, s_arvalid = 1'b0, s_rready = 1'b0;
  logic [3:0] s_awaddr = 4'h0, s_araddr = 4'h0, s_wstrb = 4'h0, temp_out_of_range = 4'h0;
  logic [31:0] s_wdata = 32'h0, s_rdata, rd_d;
  logic [1:0] s_bresp, s_rresp, rd_r;
  logic sense_open, sense_closed, shutter_drive_open, shutter_enable, shutter_open_status;
  logic shutter_closed_status, shutter_fault, overtemp_fault, interlock_ok, modulation_enable;
  logic system_run, s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
  int num_errors = 0, checks = 0, seed = 32'h3a5972f0, k;
  sif_supervisor #(.TRAVEL_CYCLES(20), .NUM_TEMP(4)) uut (.aclk, .aresetn, .shutter_cmd,
    .sys_loop_closed, .shut_loop_closed, .sense_open, .sense_closed, .shutter_drive_open,
    .shutter_enable, .temp_out_of_range, .shutter_open_status, .shutter_closed_status,
    .shutter_fault, .overtemp_fault, .interlock_ok, .modulation_enable, .system_run,
    .s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
    .s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
    .s_rready);
  sif_shutter_model #(.MOVE(8)) shm (.aclk, .drive_open(shutter_drive_open),
    .enable(shutter_enable), .slow, .stuck, .sense_open, .sense_closed);
  always #4 aclk = ~aclk;
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
    end
  endtask
  function automatic logic [6:0] exp_pins(input logic op, cl, sf, ot, ok);
    return {op & !sf & !ot, cl & !sf & !ot, sf, ot, ok, {2{ok & !sf & !ot}}};
  endfunction
  task automatic pins(input logic op, cl, sf, ot, ok);
    check("pins", {25'h0, shutter_open_status, shutter_closed_status, shutter_fault,
      overtemp_fault, interlock_ok, modulation_enable, system_run},
      {25'h0, exp_pins(op, cl, sf, ot, ok)});
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge aclk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    @(posedge aclk);
    s_awaddr <= a;
    s_wdata <= d;
    s_wstrb <= 4'h1;
    s_awvalid <= 1'b1;
    s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    // ready sampled mid-cycle where settled; transfer at next rising edge
    while (!(aw && w)) begin
      @(negedge aclk);
      rd_d[0] = s_awready;
      rd_d[1] = s_wready;
      @(posedge aclk);
      if (!aw && rd_d[0]) begin
        aw = 1'b1;
        s_awvalid <= 1'b0;
      end
      if (!w && rd_d[1]) begin
        w = 1'b1;
        s_wvalid <= 1'b0;
      end
    end
    do @(negedge aclk); while (!s_bvalid);
    rd_r = s_bresp;
    @(posedge aclk);
    s_bready <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge aclk);
    s_araddr <= a;
    s_arvalid <= 1'b1;
    s_rready <= 1'b1;
    do @(negedge aclk); while (!s_arready);
    @(posedge aclk);
    s_arvalid <= 1'b0;
    do @(negedge aclk); while (!s_rvalid);
    rd_d = s_rdata;
    rd_r = s_rresp;
    @(posedge aclk);
    s_rready <= 1'b0;
  endtask
  task automatic finish_test;
    $display("checks %0d num_errors %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  initial begin
    wt(3);
    aresetn <= 1'b1;
    rd(`SIF_ADDR_CTRL);
    check("ctrl", rd_d, {29'h0, `SIF_CTRL_RESET});
    rd(4'h8);
    check("rresp", rd_r, `SIF_RESP_SLVERR);
    wr(4'hc, 32'h1);
    check("bresp", rd_r, `SIF_RESP_SLVERR);
    sys_loop_closed <= 1'b1;
    shut_loop_closed <= 1'b1;
    wt(40);
    pins(0, 1, 0, 0, 1);
    shutter_cmd <= 1'b1;
    wt(40);
    pins(1, 0, 0, 0, 1);
    shutter_cmd <= 1'b0;
    wt(40);
    pins(0, 1, 0, 0, 1);
    sys_loop_closed <= 1'b0;
    wt(20);
    check("loop", {interlock_ok, modulation_enable, system_run}, 3'h0);
    sys_loop_closed <= 1'b1;
    // no shutter fitted: host leaves its loop open
    shut_loop_closed <= 1'b0;
    shutter_cmd <= 1'b1;
    wt(40);
    check("noshut", {shutter_drive_open, system_run, shutter_fault}, 3'h2);
    shut_loop_closed <= 1'b1;
    shutter_cmd <= 1'b0;
    wt(40);
    slow <= 1'b1;
    shutter_cmd <= 1'b1;
    wt(60);
    pins(0, 0, 1, 0, 1);
    slow <= 1'b0;
    shutter_cmd <= 1'b0;
    wt(40);
    pins(0, 0, 1, 0, 1);
    wr(`SIF_ADDR_CTRL, 32'h4);
    wt(10);
    pins(0, 1, 0, 0, 1);
    shutter_cmd <= 1'b1;
    wt(40);
    stuck <= 1'b1;
    shutter_cmd <= 1'b0;
    wt(60);
    pins(0, 0, 1, 0, 1);
    rd(`SIF_ADDR_STAT);
    check("stat", rd_d[7:0], 8'h29);
    stuck <= 1'b0;
    aresetn <= 1'b0;
    // hold reset until the blade is back closed, else closed check faults
    wt(12);
    aresetn <= 1'b1;
    wt(40);
    pins(0, 1, 0, 0, 1);
    for (int i = 0; i < 4; i++) begin
      k = $unsigned($random(seed)) % 4;
      temp_out_of_range <= 4'h1 << k;
      wt(20);
      pins(0, 1, 0, 1, 1);
      temp_out_of_range <= 4'h0;
      wt(20);
      pins(0, 1, 0, 1, 1);
      wr(`SIF_ADDR_CTRL, 32'h4);
      wt(10);
      pins(0, 1, 0, 0, 1);
    end
    finish_test;
  end
  initial begin
    wt(20000);
    num_errors++;
    finish_test;
  end
endmodule
`default_nettype wire
